//--- mqf_defines.svh
// constants for the multi-queue active flag block
`ifndef MQF_DEFINES_SVH
`define MQF_DEFINES_SVH

// queue count and address layout
`define MQF_NQ        8
`define MQF_QIDX_W    3
`define MQF_ADDR_W    8
`define MQF_DATA_W    36
`define MQF_ID_W      3

// queue switch timing in clock edges after the select edge
`define MQF_WR_SW_LAT 3
`define MQF_RD_SW_LAT 3
`define MQF_WR_GO_LAT 4

// controller write state codes
`define MQF_W_IDLE    4'h1
`define MQF_W_SEL     4'h2
`define MQF_W_WAIT    4'h4
`define MQF_W_RUN     4'h8

`endif

//--- mqf_pkg.sv
// types shared by both ends of the multi-queue flag link
`include "mqf_defines.svh"
`default_nettype none

package mqf_pkg;
  typedef logic [`MQF_ADDR_W-1:0] mqf_addr_t;
  typedef logic [`MQF_DATA_W-1:0] mqf_data_t;
  typedef logic [`MQF_QIDX_W-1:0] mqf_qidx_t;
  typedef enum logic [3:0]
  {
    MQF_W_IDLE = `MQF_W_IDLE,
    MQF_W_SEL  = `MQF_W_SEL,
    MQF_W_WAIT = `MQF_W_WAIT,
    MQF_W_RUN  = `MQF_W_RUN
  } mqf_wst_t;
endpackage

`default_nettype wire

//--- mqf_link_if.sv
// link between the queue device and the system controller
`include "mqf_defines.svh"
`default_nettype none

interface mqf_link_if;
  import mqf_pkg::*;
  // write port
  mqf_addr_t write_queue_select_bus;
  logic      write_select_strobe;
  logic      wr_en_n;
  mqf_data_t wr_data;
  logic      full_o;
  logic      full_oe;
  // read port
  mqf_addr_t read_queue_select_bus;
  logic      read_select_strobe;
  logic      rd_en_n;
  mqf_data_t rd_data;
  logic      ready_o;
  logic      ready_oe;
  // shared flag wires, pulled high when no device drives them
  logic      active_full_flag_n;
  logic      empty_or_valid_flag_n;

  assign active_full_flag_n    = full_oe ? full_o : 1'b1;
  assign empty_or_valid_flag_n = ready_oe ? ready_o : 1'b1;

  modport dev
  (
    input  write_queue_select_bus, write_select_strobe, wr_en_n, wr_data,
    input  read_queue_select_bus, read_select_strobe, rd_en_n,
    output full_o, full_oe, rd_data, ready_o, ready_oe
  );
  modport ctl
  (
    output write_queue_select_bus, write_select_strobe, wr_en_n, wr_data,
    output read_queue_select_bus, read_select_strobe, rd_en_n,
    input  rd_data, active_full_flag_n, empty_or_valid_flag_n
  );
endinterface

`default_nettype wire

//--- mqf_delay_line.sv
// fixed-length register delay line for queue select requests
`default_nettype none

module mqf_delay_line #(
  parameter int WIDTH  = 8,
  parameter int STAGES = 3
)(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_reg [STAGES];

  if (STAGES < 1 || WIDTH < 1)
  begin
    $error("delay line needs at least one stage and one bit");
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_reg[i] <= '0;
    end
    else
    begin
      stage_reg[0] <= din;
      for (int i = 1; i < STAGES; i++)
        stage_reg[i] <= stage_reg[i-1];
    end
  end

  assign dout = stage_reg[STAGES-1];
endmodule

`default_nettype wire

//--- mqf_device.sv
// multi-queue device end: per-queue status and active full / ready flags
`include "mqf_defines.svh"
`default_nettype none

module mqf_device
  import mqf_pkg::*;
#(
  parameter int DEPTH   = 16,
  parameter int ID_BITS = `MQF_ID_W
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // static identity straps
  input  wire logic device_identity_bit0,
  input  wire logic device_identity_bit1,
  input  wire logic device_identity_bit2,
  // link to the controller
  mqf_link_if.dev   lnk
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int SW = 1 + 1 + `MQF_QIDX_W;
  localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);

  // refuse shapes that the pointer and compare logic cannot serve
  if (ID_BITS < 1 || ID_BITS > `MQF_ID_W)
  begin
    $error("identity width must be 1 to 3 bits");
  end
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("queue depth must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // storage and per-queue pointers
  // ----------------------------------------------------------------
  mqf_data_t      mem [`MQF_NQ*DEPTH];
  logic [PW-1:0]  wp_reg [`MQF_NQ];
  logic [PW-1:0]  rp_reg [`MQF_NQ];

  function automatic logic [PW-1:0] fill(input logic [PW-1:0] w, input logic [PW-1:0] r);
    fill = w - r;
  endfunction

  function automatic logic [`MQF_QIDX_W+AW-1:0] slot(input mqf_qidx_t q,
                                                     input logic [PW-1:0] p);
    slot = {q, p[AW-1:0]};
  endfunction

  // ----------------------------------------------------------------
  // identity straps
  // ----------------------------------------------------------------
  logic [`MQF_ID_W-1:0] id_s1_reg;
  logic [`MQF_ID_W-1:0] id_s2_reg;
  logic [`MQF_ID_W-1:0] id_s3_reg;
  logic [`MQF_ID_W-1:0] id_reg;

  // pins settle through three flops; only an agreed value is taken
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      id_s1_reg <= '0;
      id_s2_reg <= '0;
      id_s3_reg <= '0;
      id_reg    <= '0;
    end
    else
    begin
      id_s1_reg <= {device_identity_bit2, device_identity_bit1, device_identity_bit0};
      id_s2_reg <= id_s1_reg;
      id_s3_reg <= id_s2_reg;
      if (id_s2_reg == id_s3_reg)
        id_reg <= id_s3_reg;
    end
  end

  function automatic logic id_hit(input mqf_addr_t a, input logic [`MQF_ID_W-1:0] id);
    id_hit = (a[`MQF_ADDR_W-1 -: ID_BITS] == id[ID_BITS-1:0]);
  endfunction

  // ----------------------------------------------------------------
  // select pipelines
  // ----------------------------------------------------------------
  logic [SW-1:0] wsw_dly;
  logic [SW-1:0] rsw_dly;

  mqf_delay_line #(.WIDTH(SW), .STAGES(`MQF_WR_SW_LAT)) u_wsel_dly
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({lnk.write_select_strobe, id_hit(lnk.write_queue_select_bus, id_reg),
               lnk.write_queue_select_bus[`MQF_QIDX_W-1:0]}),
    .dout    (wsw_dly)
  );

  mqf_delay_line #(.WIDTH(SW), .STAGES(`MQF_RD_SW_LAT)) u_rsel_dly
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({lnk.read_select_strobe, id_hit(lnk.read_queue_select_bus, id_reg),
               lnk.read_queue_select_bus[`MQF_QIDX_W-1:0]}),
    .dout    (rsw_dly)
  );

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  mqf_qidx_t wq_reg;
  logic      wsel_reg;
  logic      ff_n_reg;
  logic      wr_acc;
  logic      w_switch;
  mqf_qidx_t wq_next;
  logic      wsel_next;
  logic [PW-1:0] wcnt_next;

  // writes go to the old queue until the switch edge, so the fourth edge is the first new one
  assign wr_acc    = !lnk.wr_en_n && wsel_reg &&
                     fill(wp_reg[wq_reg], rp_reg[wq_reg]) != FULL_CNT;
  assign w_switch  = wsw_dly[SW-1];
  assign wq_next   = w_switch ? wsw_dly[`MQF_QIDX_W-1:0] : wq_reg;
  assign wsel_next = w_switch ? wsw_dly[SW-2] : wsel_reg;
  assign wcnt_next = fill(wp_reg[wq_next], rp_reg[wq_next]);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wq_reg   <= '0;
      wsel_reg <= 1'b0;
      ff_n_reg <= 1'b1;
    end
    else
    begin
      wq_reg   <= wq_next;
      wsel_reg <= wsel_next;
      // a write that fills the queue shows full at its own edge
      ff_n_reg <= !(wcnt_next == FULL_CNT ||
                    (wcnt_next == FULL_CNT - 1'b1 && wr_acc && wq_next == wq_reg));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr_acc)
      mem[slot(wq_reg, wp_reg[wq_reg])] <= lnk.wr_data;
  end

  assign lnk.full_o  = ff_n_reg;
  assign lnk.full_oe = wsel_reg;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  mqf_qidx_t rq_reg;
  logic      rsel_reg;
  logic      reload_reg;
  logic      or_n_reg;
  mqf_data_t dout_reg;
  logic      r_switch;
  logic      consume;
  logic      q_empty;
  logic      fetch;
  logic      rewind;

  assign r_switch = rsw_dly[SW-1];
  assign consume  = !lnk.rd_en_n && !or_n_reg && rsel_reg;
  assign q_empty  = (wp_reg[rq_reg] == rp_reg[rq_reg]);
  // no fetch on the switch edge; the next edge loads from the new queue
  assign fetch    = rsel_reg && !r_switch && !q_empty &&
                    (reload_reg || or_n_reg || consume);
  // an unread prefetched word goes back to its queue at changeover and stops
  // showing valid, so it cannot be taken twice
  assign rewind   = r_switch && rsel_reg && !or_n_reg && !consume;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rq_reg     <= '0;
      rsel_reg   <= 1'b0;
      reload_reg <= 1'b0;
      or_n_reg   <= 1'b1;
      dout_reg   <= '0;
    end
    else
    begin
      reload_reg <= r_switch;
      if (r_switch)
      begin
        rq_reg   <= rsw_dly[`MQF_QIDX_W-1:0];
        rsel_reg <= rsw_dly[SW-2];
      end
      if (fetch)
      begin
        dout_reg <= mem[slot(rq_reg, rp_reg[rq_reg])];
        or_n_reg <= 1'b0;
      end
      else if (consume || reload_reg || !rsel_reg || rewind)
        or_n_reg <= 1'b1;
    end
  end

  assign lnk.rd_data  = dout_reg;
  assign lnk.ready_o  = or_n_reg;
  assign lnk.ready_oe = rsel_reg;

  // ----------------------------------------------------------------
  // pointers, kept for every queue whether active or not
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int q = 0; q < `MQF_NQ; q++)
      begin
        wp_reg[q] <= '0;
        rp_reg[q] <= '0;
      end
    end
    else
    begin
      for (int q = 0; q < `MQF_NQ; q++)
      begin
        if (wr_acc && wq_reg == `MQF_QIDX_W'(q))
          wp_reg[q] <= wp_reg[q] + 1'b1;
        if (fetch && rq_reg == `MQF_QIDX_W'(q))
          rp_reg[q] <= rp_reg[q] + 1'b1;
        else if (rewind && rq_reg == `MQF_QIDX_W'(q))
          rp_reg[q] <= rp_reg[q] - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

//--- mqf_controller.sv
// system controller end: drives queue selects, writes and reads
`include "mqf_defines.svh"
`default_nettype none

module mqf_controller
  import mqf_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // user write side
  input  wire logic [`MQF_ADDR_W-1:0] usr_wq,
  input  wire logic                   usr_wq_go,
  input  wire logic [`MQF_DATA_W-1:0] usr_wdata,
  input  wire logic                   usr_wvalid,
  output logic                        usr_wready,
  // user read side
  input  wire logic [`MQF_ADDR_W-1:0] usr_rq,
  input  wire logic                   usr_rq_go,
  input  wire logic                   usr_rready,
  output logic [`MQF_DATA_W-1:0]      usr_rdata,
  output logic                        usr_rvalid,
  // link to the devices
  mqf_link_if.ctl                     lnk
);
  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  mqf_wst_t  wst_reg;
  logic [1:0] wcnt_reg;
  mqf_addr_t wa_reg;
  logic      wstb_reg;
  logic      wen_n_reg;
  mqf_data_t wd_reg;
  logic      wrdy_reg;
  logic      can_write;

  // one idle cycle after each write: a registered enable cannot see the
  // full flag that its own write raises, so full-rate would overrun
  assign can_write = (wst_reg == MQF_W_RUN) && usr_wvalid && !usr_wq_go &&
                     lnk.active_full_flag_n && wen_n_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wst_reg  <= MQF_W_IDLE;
      wcnt_reg <= '0;
      wa_reg   <= '0;
      wstb_reg <= 1'b0;
    end
    else
    begin
      wstb_reg <= 1'b0;
      if (usr_wq_go)
      begin
        wa_reg   <= usr_wq;
        wstb_reg <= 1'b1;
        wst_reg  <= MQF_W_SEL;
      end
      else
      begin
        unique case (wst_reg)
          MQF_W_IDLE: wst_reg <= MQF_W_IDLE;
          MQF_W_SEL:
          begin
            wcnt_reg <= '0;
            wst_reg  <= MQF_W_WAIT;
          end
          MQF_W_WAIT:
          begin
            wcnt_reg <= wcnt_reg + 1'b1;
            // open on the flag edge, so the first write decision sees the new queue
            if (wcnt_reg == 2'(`MQF_WR_SW_LAT - 1))
              wst_reg <= MQF_W_RUN;
          end
          MQF_W_RUN:  wst_reg <= MQF_W_RUN;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wen_n_reg <= 1'b1;
      wd_reg    <= '0;
      wrdy_reg  <= 1'b0;
    end
    else
    begin
      wen_n_reg <= !can_write;
      wrdy_reg  <= can_write;
      if (can_write)
        wd_reg <= usr_wdata;
    end
  end

  assign lnk.write_queue_select_bus = wa_reg;
  assign lnk.write_select_strobe    = wstb_reg;
  assign lnk.wr_en_n                = wen_n_reg;
  assign lnk.wr_data                = wd_reg;
  assign usr_wready                 = wrdy_reg;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  mqf_addr_t ra_reg;
  logic      rstb_reg;
  logic      ren_n_reg;
  mqf_data_t rd_reg;
  logic      rv_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ra_reg    <= '0;
      rstb_reg  <= 1'b0;
      ren_n_reg <= 1'b1;
      rd_reg    <= '0;
      rv_reg    <= 1'b0;
    end
    else
    begin
      rstb_reg  <= usr_rq_go;
      if (usr_rq_go)
        ra_reg <= usr_rq;
      ren_n_reg <= !usr_rready;
      // a word is taken on an edge with read enable low and ready low
      rv_reg    <= !ren_n_reg && !lnk.empty_or_valid_flag_n;
      if (!ren_n_reg && !lnk.empty_or_valid_flag_n)
        rd_reg <= lnk.rd_data;
    end
  end

  assign lnk.read_queue_select_bus = ra_reg;
  assign lnk.read_select_strobe    = rstb_reg;
  assign lnk.rd_en_n               = ren_n_reg;
  assign usr_rdata                 = rd_reg;
  assign usr_rvalid                = rv_reg;
endmodule

`default_nettype wire

//--- mqf_link_asserts.sv
// concurrent checks on the flag link between queue device and controller
`default_nettype none

module mqf_link_asserts
  import mqf_pkg::*;
#(
  parameter int         ID_BITS = 3,
  parameter logic [2:0] DEV_ID  = 3'h0
)(
  // clock and reset
  input wire logic      clk_sys,
  input wire logic      rst,
  // write port
  input wire mqf_addr_t write_queue_select_bus,
  input wire logic      write_select_strobe,
  input wire logic      wr_en_n,
  input wire logic      full_oe,
  input wire logic      active_full_flag_n,
  // read port
  input wire mqf_addr_t read_queue_select_bus,
  input wire logic      read_select_strobe,
  input wire logic      rd_en_n,
  input wire logic      ready_o,
  input wire logic      ready_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic w_hit;
  logic r_hit;

  assign w_hit = write_queue_select_bus[7 -: ID_BITS] == DEV_ID[ID_BITS-1:0];
  assign r_hit = read_queue_select_bus[7 -: ID_BITS] == DEV_ID[ID_BITS-1:0];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // write port
  // ----------------------------------------
  property p_wsel_hit;
    write_select_strobe && w_hit ##1 !write_select_strobe [*2] |=> ##1 full_oe;
  endproperty
  a_wsel_hit : assert property (p_wsel_hit) else $error("full flag not driven");

  property p_wsel_miss;
    write_select_strobe && !w_hit ##1 !write_select_strobe [*2] |=> ##1 !full_oe;
  endproperty
  a_wsel_miss : assert property (p_wsel_miss) else $error("full flag not floated");

  // an earlier select would legally land inside the window
  property p_full_hold;
    write_select_strobe && !$past(write_select_strobe) && !$past(write_select_strobe, 2)
      && !$past(write_select_strobe, 3) |=> $stable(full_oe) [*3];
  endproperty
  a_full_hold : assert property (p_full_hold) else $error("full drive changed early");

  property p_wr_gap;
    !wr_en_n |=> wr_en_n;
  endproperty
  a_wr_gap : assert property (p_wr_gap) else $error("writes closer than two cycles");

  property p_wr_wait;
    write_select_strobe |=> wr_en_n [*3];
  endproperty
  a_wr_wait : assert property (p_wr_wait) else $error("write before new queue open");

  property p_no_wr_full;
    !active_full_flag_n |=> wr_en_n;
  endproperty
  a_no_wr_full : assert property (p_no_wr_full) else $error("write while flag full");

  // ----------------------------------------
  // read port
  // ----------------------------------------
  property p_rsel_hit;
    read_select_strobe && r_hit ##1 !read_select_strobe [*2] |=> ##1 ready_oe;
  endproperty
  a_rsel_hit : assert property (p_rsel_hit) else $error("ready flag not driven");

  property p_rsel_miss;
    read_select_strobe && !r_hit ##1 !read_select_strobe [*2] |=> ##1 !ready_oe;
  endproperty
  a_rsel_miss : assert property (p_rsel_miss) else $error("ready flag not floated");

  property p_ready_hold;
    !ready_o && ready_oe && rd_en_n && !read_select_strobe && !$past(read_select_strobe)
      && !$past(read_select_strobe, 2) && !$past(read_select_strobe, 3) |=> !ready_o;
  endproperty
  a_ready_hold : assert property (p_ready_hold) else $error("valid word lost unread");

  c_wsel_hit   : cover property (write_select_strobe && w_hit);
  c_full_fell  : cover property ($fell(active_full_flag_n));
  c_rsel_miss  : cover property (read_select_strobe && !r_hit);
  c_read_taken : cover property (!rd_en_n && !ready_o);
endmodule

`default_nettype wire

//--- tb_multiqueue_active_flags.sv
// self-checking bench: device and controller joined over the flag link
`default_nettype none

module tb_multiqueue_active_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import mqf_pkg::*;

  localparam int         DEPTH  = 4;
  localparam logic [2:0] DEV_ID = 3'h5;

  logic      clk_sys;
  logic      rst;
  mqf_addr_t usr_wq;
  mqf_addr_t usr_rq;
  logic      usr_wq_go;
  logic      usr_wvalid;
  logic      usr_rq_go;
  logic      usr_rready;
  mqf_data_t usr_wdata;
  mqf_data_t usr_rdata;
  logic      usr_wready;
  logic      usr_rvalid;
  int        failures;
  int        num_checks;

  mqf_link_if lnk ();

  mqf_device #(.DEPTH(DEPTH), .ID_BITS(3)) mqf_device_i (
    .clk_sys(clk_sys), .rst(rst), .device_identity_bit0(DEV_ID[0]),
    .device_identity_bit1(DEV_ID[1]), .device_identity_bit2(DEV_ID[2]), .lnk(lnk));

  mqf_controller mqf_controller_i (
    .clk_sys(clk_sys), .rst(rst), .usr_wq(usr_wq), .usr_wq_go(usr_wq_go),
    .usr_wdata(usr_wdata), .usr_wvalid(usr_wvalid), .usr_wready(usr_wready),
    .usr_rq(usr_rq), .usr_rq_go(usr_rq_go), .usr_rready(usr_rready),
    .usr_rdata(usr_rdata), .usr_rvalid(usr_rvalid), .lnk(lnk));

  mqf_link_asserts #(.ID_BITS(3), .DEV_ID(DEV_ID)) mqf_link_asserts_i (
    .clk_sys(clk_sys), .rst(rst), .write_queue_select_bus(lnk.write_queue_select_bus),
    .write_select_strobe(lnk.write_select_strobe), .wr_en_n(lnk.wr_en_n),
    .full_oe(lnk.full_oe), .active_full_flag_n(lnk.active_full_flag_n),
    .read_queue_select_bus(lnk.read_queue_select_bus),
    .read_select_strobe(lnk.read_select_strobe), .rd_en_n(lnk.rd_en_n),
    .ready_o(lnk.ready_o), .ready_oe(lnk.ready_oe));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic mqf_data_t word_of(input int q, input int i);
    return {4'h5, 8'(q), 24'(i)};
  endfunction

  task automatic chk(input mqf_data_t got, input mqf_data_t exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // select a queue; the flag drive (and on writes the flag) must stay put until the third edge after the strobe
  task automatic sel(input logic rd, input mqf_addr_t a, input logic exp_oe,
                     input logic exp_flag, input mqf_data_t exp_word);
    logic oe0;
    logic fl0;
    @(posedge clk_sys);
    if (rd)
    begin
      usr_rq    <= a;
      usr_rq_go <= 1'b1;
    end
    else
    begin
      usr_wq    <= a;
      usr_wq_go <= 1'b1;
    end
    @(posedge clk_sys);
    usr_rq_go <= 1'b0;
    usr_wq_go <= 1'b0;
    @(negedge clk_sys);
    for (int n = 0; n < 20 && (rd ? lnk.read_select_strobe : lnk.write_select_strobe) !== 1'b1;
         n++) @(negedge clk_sys);
    oe0 = rd ? lnk.ready_oe : lnk.full_oe;
    fl0 = rd ? lnk.empty_or_valid_flag_n : lnk.active_full_flag_n;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(rd ? lnk.ready_oe : lnk.full_oe, oe0);
    if (!rd)
      chk(lnk.active_full_flag_n, fl0);
    @(negedge clk_sys);
    chk(rd ? lnk.ready_oe : lnk.full_oe, exp_oe);
    if (!rd)
      chk(lnk.active_full_flag_n, exp_flag);
    else
    begin
      @(negedge clk_sys);
      chk(lnk.empty_or_valid_flag_n, exp_flag);
      if (!exp_flag)
        chk(lnk.rd_data, exp_word);
    end
  endtask

  task automatic put(input mqf_data_t d);
    @(posedge clk_sys);
    usr_wdata  <= d;
    usr_wvalid <= 1'b1;
    @(negedge clk_sys);
    for (int n = 0; n < 50 && usr_wready !== 1'b1; n++) @(negedge clk_sys);
    chk(usr_wready, 1'b1);
    @(posedge clk_sys);
    usr_wvalid <= 1'b0;
  endtask

  task automatic drain(input int q, input int cnt);
    @(posedge clk_sys);
    usr_rready <= 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      @(negedge clk_sys);
      for (int n = 0; n < 50 && usr_rvalid !== 1'b1; n++) @(negedge clk_sys);
      chk(usr_rdata, word_of(q, i));
    end
    repeat (4) @(negedge clk_sys);
    chk(lnk.empty_or_valid_flag_n, 1'b1);
    @(posedge clk_sys);
    usr_rready <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write_select();
    sel(1'b0, 8'h20, 1'b0, 1'b1, '0);
    sel(1'b0, 8'ha1, 1'b1, 1'b1, '0);
    $display("test write select done");
  endtask

  task automatic t_fill();
    int hits;
    for (int i = 0; i < DEPTH; i++) put(word_of(1, i));
    repeat (3) @(negedge clk_sys);
    chk(lnk.active_full_flag_n, 1'b0);
    @(posedge clk_sys);
    usr_wdata  <= word_of(1, DEPTH);
    usr_wvalid <= 1'b1;
    hits = 0;
    repeat (30)
    begin
      @(negedge clk_sys);
      if (usr_wready !== 1'b0)
        hits++;
    end
    chk(hits, 0);
    @(posedge clk_sys);
    usr_wvalid <= 1'b0;
    sel(1'b0, 8'ha0, 1'b1, 1'b1, '0);
    sel(1'b0, 8'ha1, 1'b1, 1'b0, '0);
    $display("test fill done");
  endtask

  task automatic t_read();
    sel(1'b0, 8'ha0, 1'b1, 1'b1, '0);
    sel(1'b1, 8'ha1, 1'b1, 1'b0, word_of(1, 0));
    drain(1, DEPTH);
    sel(1'b0, 8'ha1, 1'b1, 1'b1, '0);
    $display("test read done");
  endtask

  task automatic t_fall_through();
    sel(1'b1, 8'ha2, 1'b1, 1'b1, '0);
    sel(1'b0, 8'ha2, 1'b1, 1'b1, '0);
    put(word_of(2, 0));
    drain(2, 1);
    sel(1'b0, 8'ha3, 1'b1, 1'b1, '0);
    put(word_of(3, 0));
    sel(1'b1, 8'ha3, 1'b1, 1'b0, word_of(3, 0));
    drain(3, 1);
    sel(1'b1, 8'h23, 1'b0, 1'b1, '0);
    $display("test fall through done");
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    chk(1'b0, 1'b1);
    stop_test();
  end

  initial
  begin
    rst        = 1'b1;
    usr_wq     = '0;
    usr_rq     = '0;
    usr_wq_go  = 1'b0;
    usr_rq_go  = 1'b0;
    usr_wvalid = 1'b0;
    usr_rready = 1'b0;
    usr_wdata  = '0;
    failures   = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    t_write_select();
    t_fill();
    t_read();
    t_fall_through();
    stop_test();
  end
endmodule

`default_nettype wire
